// ### rtl/split_reload_capture_timer.sv
// split reload/capture timer with special function register access
`timescale 1ns/10ps
`include "split_timer_defines.svh"

module split_reload_capture_timer (
  // clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_nrst,
  // special function register bus
  input  wire logic [7:0]            i_sfr_addr,
  input  wire logic                  i_sfr_wr,
  input  wire split_timer_pkg::sfr_byte_t i_sfr_wdata,
  output split_timer_pkg::sfr_byte_t o_sfr_rdata,
  // count tick from the core clock domain
  input  wire logic                  i_tick,
  // capture event pins, asynchronous
  input  wire logic                  i_capture_low,
  input  wire logic                  i_capture_high,
  // interrupt request
  output logic                       o_irq
);
  import split_timer_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  sfr_byte_t ctrl_q, ctrl_d;
  count_t    count_q, count_d;
  count_t    reload_q, reload_d;
  sfr_byte_t rdata_q, rdata_d;
  logic [1:0] sync1_q, sync2_q, sync3_q;
  logic [1:0] sync1_d, sync2_d, sync3_d;

  // ****************************************************************
  // decode of control fields
  // ****************************************************************
  logic split, run_l, run_h, cap_mode_l, cap_mode_h, irq_en;
  logic tick_l, tick_h, ovf_l, ovf_h, cap_ev_l, cap_ev_h;
  logic set_flag_l, set_flag_h;
  logic wr_ctrl, wr_rl, wr_rh, wr_cl, wr_ch;

  assign split      = ctrl_q[`BIT_SPLIT_SELECT];
  assign run_l      = ctrl_q[`BIT_LOW_HALF_RUN];
  assign run_h      = ctrl_q[`BIT_HIGH_HALF_RUN];
  assign irq_en     = ctrl_q[`BIT_LOW_HALF_IRQ_ENABLE];
  // the high capture bit is ignored in wide mode
  assign cap_mode_l = ctrl_q[`BIT_LOW_HALF_CAP_ENABLE];
  assign cap_mode_h = split ? ctrl_q[`BIT_HIGH_HALF_CAP_ENABLE]
                            : ctrl_q[`BIT_LOW_HALF_CAP_ENABLE];

  // write strobes, address decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_rl   = 1'b0;
    wr_rh   = 1'b0;
    wr_cl   = 1'b0;
    wr_ch   = 1'b0;
    if (i_sfr_addr == `ADDR_TIMER_CONTROL) begin
      wr_ctrl = i_sfr_wr;
    end else if (i_sfr_addr == `ADDR_RELOAD_CAPTURE_LOW) begin
      wr_rl = i_sfr_wr;
    end else if (i_sfr_addr == `ADDR_RELOAD_CAPTURE_HIGH) begin
      wr_rh = i_sfr_wr;
    end else if (i_sfr_addr == `ADDR_COUNT_LOW) begin
      wr_cl = i_sfr_wr;
    end else if (i_sfr_addr == `ADDR_COUNT_HIGH) begin
      wr_ch = i_sfr_wr;
    end
  end

  // ****************************************************************
  // capture pin synchronisers and edge detect
  // ****************************************************************
  // the first stage feeds only the second; edges come from stages 2 and 3
  always_comb begin
    sync1_d = {i_capture_high, i_capture_low};
    sync2_d = sync1_q;
    sync3_d = sync2_q;
  end

  // wide mode uses the low capture pin for the whole counter
  assign cap_ev_l = sync2_q[0] & ~sync3_q[0];
  assign cap_ev_h = split ? (sync2_q[1] & ~sync3_q[1]) : cap_ev_l;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= 2'b00;
      sync2_q <= 2'b00;
      sync3_q <= 2'b00;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
    end
  end

  // ****************************************************************
  // counting, overflow and capture events
  // ****************************************************************
  // in wide mode either run bit starts the whole counter
  assign tick_l = i_tick & (split ? run_l : (run_l | run_h));
  assign tick_h = split ? (i_tick & run_h)
                        : (tick_l & (count_q[7:0] == `BYTE_ALL_ONES));
  assign ovf_l  = tick_l & (count_q[7:0] == `BYTE_ALL_ONES);
  assign ovf_h  = tick_h & (count_q[15:8] == `BYTE_ALL_ONES);

  // flag sources: wide capture turns the low flag into a 17th bit
  always_comb begin
    if (split) begin
      set_flag_l = cap_mode_l ? cap_ev_l : ovf_l;
      set_flag_h = cap_mode_h ? cap_ev_h : ovf_h;
    end else if (cap_mode_l) begin
      set_flag_l = ovf_h;
      set_flag_h = cap_ev_l;
    end else begin
      set_flag_l = ovf_l;
      set_flag_h = ovf_h;
    end
  end

  // next count, reload/capture and control values
  always_comb begin
    count_d  = count_q;
    reload_d = reload_q;
    ctrl_d   = ctrl_q;
    // low half, outside capture mode: reloads on its own wrap in split timer mode, on the 16-bit wrap in wide mode
    if (tick_l) begin
      if (split && ovf_l && !cap_mode_l) begin
        count_d[7:0] = reload_q[7:0];
      end else if (!split && ovf_h && !cap_mode_l) begin
        count_d[7:0] = reload_q[7:0];
      end else begin
        count_d[7:0] = count_q[7:0] + 8'h01;
      end
    end
    if (tick_h) begin
      if (ovf_h && !cap_mode_h) begin
        count_d[15:8] = reload_q[15:8];
      end else begin
        count_d[15:8] = count_q[15:8] + 8'h01;
      end
    end
    // captures store the live count into the reload/capture bytes
    if (cap_mode_l && cap_ev_l) begin
      reload_d[7:0] = count_q[7:0];
    end
    if (cap_mode_h && cap_ev_h) begin
      reload_d[15:8] = count_q[15:8];
    end
    // software writes act at once, no shadow stage
    if (wr_rl) begin
      reload_d[7:0] = i_sfr_wdata;
    end
    if (wr_rh) begin
      reload_d[15:8] = i_sfr_wdata;
    end
    if (wr_cl) begin
      count_d[7:0] = i_sfr_wdata;
    end
    if (wr_ch) begin
      count_d[15:8] = i_sfr_wdata;
    end
    if (wr_ctrl) begin
      ctrl_d = i_sfr_wdata;
    end
    // a hardware set wins over a software clear in the same cycle
    if (set_flag_l) begin
      ctrl_d[`BIT_LOW_HALF_FLAG] = 1'b1;
    end
    if (set_flag_h) begin
      ctrl_d[`BIT_HIGH_HALF_FLAG] = 1'b1;
    end
  end

  // registered read data, one cycle after the address
  always_comb begin
    if (i_sfr_addr == `ADDR_TIMER_CONTROL) begin
      rdata_d = ctrl_q;
    end else if (i_sfr_addr == `ADDR_RELOAD_CAPTURE_LOW) begin
      rdata_d = reload_q[7:0];
    end else if (i_sfr_addr == `ADDR_RELOAD_CAPTURE_HIGH) begin
      rdata_d = reload_q[15:8];
    end else if (i_sfr_addr == `ADDR_COUNT_LOW) begin
      rdata_d = count_q[7:0];
    end else if (i_sfr_addr == `ADDR_COUNT_HIGH) begin
      rdata_d = count_q[15:8];
    end else begin
      rdata_d = `READ_UNMAPPED;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q   <= `RESET_BYTE;
      count_q  <= {`RESET_BYTE, `RESET_BYTE};
      reload_q <= {`RESET_BYTE, `RESET_BYTE};
      rdata_q  <= `RESET_BYTE;
    end else begin
      ctrl_q   <= ctrl_d;
      count_q  <= count_d;
      reload_q <= reload_d;
      rdata_q  <= rdata_d;
    end
  end

  assign o_sfr_rdata = rdata_q;
  // level request, follows the flags with no extra delay
  assign o_irq = ctrl_q[`BIT_HIGH_HALF_FLAG]
               | (ctrl_q[`BIT_LOW_HALF_FLAG] & irq_en);

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  a_irq_equation: assert property (
    o_irq == (ctrl_q[7] | (ctrl_q[6] & ctrl_q[5])))
    else $error("interrupt request does not match flags");

  a_wide_carry: assert property (
    (!split && tick_l && !cap_mode_l && count_q[7:0] == 8'hFF
     && count_q[15:8] != 8'hFF && !wr_cl && !wr_ch)
    |=> count_q[15:8] == $past(count_q[15:8]) + 8'h01)
    else $error("wide counter high byte did not take the carry");

  a_split_hold_high: assert property (
    (split && !run_h && !wr_ch) |=> $stable(count_q[15:8]))
    else $error("stopped high half moved");

  a_split_low_run: assert property (
    (split && run_l && i_tick && !wr_cl && count_q[7:0] != 8'hFF)
    |=> count_q[7:0] == $past(count_q[7:0]) + 8'h01)
    else $error("running low half did not count");

  a_reload_low: assert property (
    (split && ovf_l && !cap_mode_l && !wr_cl && !wr_rl)
    |=> count_q[7:0] == $past(reload_q[7:0]) && ctrl_q[6])
    else $error("low half did not reload on overflow");

  a_reload_wide: assert property (
    (!split && ovf_h && !cap_mode_l && !wr_cl && !wr_ch
     && !wr_rl && !wr_rh)
    |=> count_q == $past(reload_q) && ctrl_q[7])
    else $error("wide counter did not reload on overflow");

  a_capture_low: assert property (
    (cap_mode_l && cap_ev_l && !wr_rl) |=> reload_q[7:0] == $past(count_q[7:0]))
    else $error("capture did not store the count");

  a_write_immediate: assert property (
    (wr_rh && !(cap_mode_h && cap_ev_h)) ##1 1'b1
    |-> reload_q[15:8] == $past(i_sfr_wdata))
    else $error("reload high write did not take effect");

  a_flag_sticky: assert property (
    (ctrl_q[7] && !wr_ctrl) |=> ctrl_q[7] [*2] or (ctrl_q[7] ##1 !ctrl_q[7] && $past(wr_ctrl)))
    else $error("high flag cleared without software");

  a_set_wins: assert property (
    set_flag_h |=> ctrl_q[7])
    else $error("high flag event lost");

  a_split_select: assert property (
    (!split && !run_l && !run_h && !wr_cl && !wr_ch) |=> $stable(count_q))
    else $error("wide counter moved while stopped");

  // wide capture: the pin copies all 16 bits and sets the high flag
  a_wide_capture: assert property (
    (!split && cap_mode_l && cap_ev_l && !wr_rl && !wr_rh)
    |=> reload_q == $past(count_q) && ctrl_q[`BIT_HIGH_HALF_FLAG])
    else $error("wide capture did not copy the count");

  // the 17th bit: a wrap in wide capture mode goes to zero and flags low
  a_wide_cap_wrap: assert property (
    (!split && cap_mode_l && ovf_h && !wr_cl && !wr_ch)
    |=> count_q == 16'h0000 && ctrl_q[`BIT_LOW_HALF_FLAG])
    else $error("wide capture wrap did not clear the count");

  a_split_low_capture: assert property (
    (split && cap_mode_l && cap_ev_l) |=> ctrl_q[`BIT_LOW_HALF_FLAG])
    else $error("low half capture did not set its flag");

  a_split_low_stop: assert property (
    (split && !run_l && !wr_cl) |=> $stable(count_q[7:0]))
    else $error("stopped low half moved");

  a_low_sticky: assert property (
    (ctrl_q[`BIT_LOW_HALF_FLAG] && !wr_ctrl) |=> ctrl_q[`BIT_LOW_HALF_FLAG])
    else $error("low flag cleared without software");

  // count writes beat the increment in the same cycle
  a_count_low_write: assert property (
    wr_cl |=> count_q[7:0] == $past(i_sfr_wdata))
    else $error("count low write was lost");

  a_count_high_write: assert property (
    wr_ch |=> count_q[15:8] == $past(i_sfr_wdata))
    else $error("count high write was lost");

  // read data is the addressed register one cycle later
  a_read_count_low: assert property (
    (i_sfr_addr == `ADDR_COUNT_LOW) |=> o_sfr_rdata == $past(count_q[7:0]))
    else $error("count low read returned the wrong byte");

endmodule

// ### rtl/split_timer_defines.svh
// constants for the split reload/capture timer
// ****************************************************************
// ****************************************************************
`ifndef SPLIT_TIMER_DEFINES_SVH
`define SPLIT_TIMER_DEFINES_SVH

// special function register addresses
`define ADDR_TIMER_CONTROL        8'hB9
`define ADDR_RELOAD_CAPTURE_LOW   8'hBA
`define ADDR_RELOAD_CAPTURE_HIGH  8'hBB
`define ADDR_COUNT_LOW            8'hBC
`define ADDR_COUNT_HIGH           8'hBD

// timer_control bit positions
`define BIT_HIGH_HALF_FLAG        7
`define BIT_LOW_HALF_FLAG         6
`define BIT_LOW_HALF_IRQ_ENABLE   5
`define BIT_SPLIT_SELECT          4
`define BIT_HIGH_HALF_CAP_ENABLE  3
`define BIT_LOW_HALF_CAP_ENABLE   2
`define BIT_HIGH_HALF_RUN         1
`define BIT_LOW_HALF_RUN          0

// reset values and constants
`define RESET_BYTE                8'h00
`define BYTE_ALL_ONES             8'hFF
`define READ_UNMAPPED             8'h00

`endif

// ### rtl/split_timer_pkg.sv
// types shared by the split reload/capture timer
package split_timer_pkg;
  typedef logic [7:0]  sfr_byte_t;
  typedef logic [15:0] count_t;
endpackage

// ### verification/sfr_core_model.sv
// core-side register bus master model for the split timer
`timescale 1ns/10ps

module sfr_core_model (
  // clock
  input  wire logic                       i_clock,
  // register bus
  output logic [7:0]                      o_sfr_addr,
  output logic                            o_sfr_wr,
  output split_timer_pkg::sfr_byte_t      o_sfr_wdata,
  input  wire split_timer_pkg::sfr_byte_t i_sfr_rdata
);
  import split_timer_pkg::*;

  // bus starts on an unmapped address; the tasks leave the last address driven
  initial begin
    o_sfr_addr  = 8'h00;
    o_sfr_wr    = 1'b0;
    o_sfr_wdata = 8'h00;
  end

  // strobe and data held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input sfr_byte_t d);
    @(negedge i_clock);
    o_sfr_addr  = a;
    o_sfr_wdata = d;
    o_sfr_wr    = 1'b1;
    @(negedge i_clock);
    o_sfr_wr    = 1'b0;
    o_sfr_wdata = ~d; // released data must not look valid
  endtask

  // read data is registered, so take it one edge after the address
  task automatic rd(input logic [7:0] a, output sfr_byte_t d);
    @(negedge i_clock);
    o_sfr_addr = a;
    @(negedge i_clock);
    d = i_sfr_rdata;
  endtask
endmodule

// ### verification/split_reload_capture_timer_tb_top.sv
// self-checking bench for the split reload/capture timer
`timescale 1ns/10ps
`include "split_timer_defines.svh"

module split_reload_capture_timer_tb_top;
  import split_timer_pkg::*;
  localparam logic [7:0] CT = `ADDR_TIMER_CONTROL;
  localparam logic [7:0] RL = `ADDR_RELOAD_CAPTURE_LOW;
  localparam logic [7:0] RH = `ADDR_RELOAD_CAPTURE_HIGH;
  localparam logic [7:0] CL = `ADDR_COUNT_LOW;
  localparam logic [7:0] CH = `ADDR_COUNT_HIGH;
  logic       clk = 1'b0;
  logic       nrst;
  logic [7:0] addr;
  logic       wr;
  sfr_byte_t  wdata;
  sfr_byte_t  rdata;
  logic       tick;
  logic       cap_lo;
  logic       cap_hi;
  logic       irq;
  int         fails = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  always #5 clk = ~clk;

  sfr_core_model u_sfr_core_model (.i_clock(clk), .o_sfr_addr(addr), .o_sfr_wr(wr),
    .o_sfr_wdata(wdata), .i_sfr_rdata(rdata));

  split_reload_capture_timer u_split_reload_capture_timer (.i_clock(clk), .i_nrst(nrst),
    .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_tick(tick), .i_capture_low(cap_lo), .i_capture_high(cap_hi), .o_irq(irq));

  task automatic check(input sfr_byte_t got, input sfr_byte_t exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input sfr_byte_t exp);
    sfr_byte_t d;
    u_sfr_core_model.rd(a, d);
    check(d, exp);
  endtask

  // irq sampled at the falling edge, well after any flag update
  task automatic ichk(input logic exp);
    @(negedge clk);
    check({7'h00, irq}, {7'h00, exp});
  endtask

  // n rising edges with the count enable high
  task automatic ticks(input int n);
    @(negedge clk);
    tick = 1'b1;
    repeat (n) @(negedge clk);
    tick = 1'b0;
  endtask

  // pin held long enough to pass the synchronisers
  task automatic cap(input logic [1:0] w);
    {cap_hi, cap_lo} = w;
    repeat (4) @(negedge clk);
    {cap_hi, cap_lo} = 2'b00;
    repeat (4) @(negedge clk);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // a hang shows up as a mismatch, far beyond the under two hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    nrst   = 1'b0;
    tick   = 1'b0;
    cap_lo = 1'b0;
    cap_hi = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    // reset values, then an unmapped place that ignores writes
    for (int a = 'hB9; a <= 'hBD; a++) rchk(8'(a), 8'h00);
    u_sfr_core_model.wr(8'hB8, 8'hA5);
    rchk(8'hB8, 8'h00);
    // split low half wraps to its reload value and flags
    u_sfr_core_model.wr(RL, 8'hF0);
    u_sfr_core_model.wr(CL, 8'hFF);
    u_sfr_core_model.wr(CT, 8'h31);
    ticks(1);
    rchk(CL, 8'hF0);
    rchk(RL, 8'hF0);
    rchk(CH, 8'h00);
    rchk(CT, 8'h71);
    ichk(1'b1);
    u_sfr_core_model.wr(CT, 8'h50);
    ichk(1'b0);
    // split high half runs alone and raises irq without enable
    u_sfr_core_model.wr(RH, 8'h80);
    u_sfr_core_model.wr(CH, 8'hFE);
    u_sfr_core_model.wr(CT, 8'h12);
    ticks(2);
    rchk(CH, 8'h80);
    rchk(CL, 8'hF0);
    rchk(CT, 8'h92);
    ichk(1'b1);
    // wide mode: high run bit alone moves the carry
    u_sfr_core_model.wr(RL, 8'h34);
    u_sfr_core_model.wr(RH, 8'h12);
    u_sfr_core_model.wr(CL, 8'hFF);
    u_sfr_core_model.wr(CH, 8'h00);
    u_sfr_core_model.wr(CT, 8'h02);
    ichk(1'b0);
    ticks(1);
    rchk(CL, 8'h00);
    rchk(CH, 8'h01);
    rchk(CT, 8'h42);
    // 16-bit overflow reloads both bytes
    u_sfr_core_model.wr(CT, 8'h01);
    u_sfr_core_model.wr(CL, 8'hFF);
    u_sfr_core_model.wr(CH, 8'hFF);
    ticks(1);
    rchk(CL, 8'h34);
    rchk(CH, 8'h12);
    rchk(CT, 8'hC1);
    // one reload byte written alone is used at once
    u_sfr_core_model.wr(RL, 8'h55);
    u_sfr_core_model.wr(CL, 8'hFF);
    u_sfr_core_model.wr(CH, 8'hFF);
    ticks(1);
    rchk(CL, 8'h55);
    rchk(CH, 8'h12);
    // wide capture copies all 16 bits into the reload bytes
    u_sfr_core_model.wr(CT, 8'h04);
    u_sfr_core_model.wr(CL, 8'h78);
    u_sfr_core_model.wr(CH, 8'h56);
    cap(2'b01);
    rchk(RL, 8'h78);
    rchk(RH, 8'h56);
    rchk(CT, 8'h84);
    // split high capture touches only its own byte
    u_sfr_core_model.wr(CT, 8'h18);
    u_sfr_core_model.wr(CH, 8'h9A);
    cap(2'b10);
    rchk(RH, 8'h9A);
    rchk(RL, 8'h78);
    rchk(CT, 8'h98);
    // split low capture stores only its byte, the enable gates irq
    u_sfr_core_model.wr(CT, 8'h14);
    u_sfr_core_model.wr(CL, 8'h3C);
    cap(2'b01);
    rchk(RL, 8'h3C);
    rchk(RH, 8'h9A);
    rchk(CT, 8'h54);
    ichk(1'b0);
    // wide capture mode wraps to zero, the low flag acts as a 17th bit
    u_sfr_core_model.wr(CT, 8'h05);
    u_sfr_core_model.wr(CL, 8'hFF);
    u_sfr_core_model.wr(CH, 8'hFF);
    ticks(1);
    rchk(CL, 8'h00);
    rchk(CH, 8'h00);
    rchk(RL, 8'h3C);
    rchk(CT, 8'h45);
    // a reset with the high flag pending clears every register and the request
    u_sfr_core_model.wr(CT, 8'hA0);
    ichk(1'b1);
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    ichk(1'b0);
    rchk(CT, 8'h00);
    rchk(RL, 8'h00);
    rchk(CH, 8'h00);
    results();
  end
endmodule
